// ---- cascade_gs_pkg.sv ----
// shared constants and types for the cascaded grayscale bank block
// assumes a serial chain clocked by the controller and a 125 MHz core clock
package cascade_gs_pkg;

    // serial framing
    localparam int DATA_BITS = 16;
    localparam int WORD_BITS = DATA_BITS + 1;
    localparam int WORDS_PER_UNIT = 3;
    localparam int END_ONES = 18;
    localparam int OWN_BITS = WORDS_PER_UNIT * WORD_BITS;
    localparam int DLY_LEN = OWN_BITS + END_ONES;

    // read insertion phases, counted in link bits after the end marker
    localparam int INJ_START = OWN_BITS + 1;
    localparam int INJ_END = INJ_START + OWN_BITS - 1;
    localparam int INJ_DONE = INJ_END + END_ONES;

    // memory geometry defaults
    localparam int UNIT_BITS = WORDS_PER_UNIT * DATA_BITS;
    localparam int UNIT_COUNT = 16;
    localparam int LINE_COUNT = 64;

    // last scan-line index field of config word zero
    localparam int SCAN_LSB = 16;
    localparam int SCAN_MSB = 21;

    // command identifiers seen in the head word
    localparam logic [15:0] CMD_GS_WRITE = 16'haa30;
    localparam logic [15:0] CMD_VSYNC = 16'haaf0;
    localparam logic [15:0] CMD_GS_READ = 16'haa31;

    // values after reset
    localparam logic BANK_SEL_RESET = 1'b0;
    localparam logic LINE_IDLE_LEVEL = 1'b1;

    typedef enum logic [3:0] {
        L_IDLE = 4'h1,
        L_HEAD = 4'h2,
        L_BODY = 4'h4,
        L_INJECT = 4'h8
    } link_state_t;

    typedef enum logic [1:0] {
        K_NONE = 2'h0,
        K_GS_WRITE = 2'h1,
        K_VSYNC = 2'h2,
        K_READ = 2'h3
    } cmd_kind_t;

    // one memory unit: blue high, red low
    typedef struct packed {
        logic [15:0] blue;
        logic [15:0] green;
        logic [15:0] red;
    } gs_unit_t;

    // frame event handed from link to core
    typedef struct packed {
        cmd_kind_t kind;
        gs_unit_t unit;
    } link_event_t;

endpackage

// ---- sig_sync.sv ----
// two-flop synchroniser for a group of independent levels
// assumes each bit changes no faster than two destination cycles
`timescale 1ns/1ps
`default_nettype none
module sig_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels in and out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("sig_sync width must be at least one");
    end

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // sig_sync
`default_nettype wire

// ---- cascade_gs_memory_banks.sv ----
// serial chain data path and double-buffered grayscale memory
// assumes a free-running chain clock and a core clock of its own
`timescale 1ns/1ps
`default_nettype none
module cascade_gs_memory_banks #(
    parameter int NUM_LINES = cascade_gs_pkg::LINE_COUNT,
    parameter int NUM_UNITS = cascade_gs_pkg::UNIT_COUNT,
    localparam int LW = $clog2(NUM_LINES),
    localparam int UW = $clog2(NUM_UNITS)
) (
    // core clock, reset and enable
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // serial chain link
    input wire logic chain_clk,
    input wire logic chain_serial_in,
    output logic chain_serial_out,
    // configuration and readback source
    input wire logic [47:0] config_word_zero,
    input wire logic [47:0] readback_data,
    // display read port
    input wire logic [LW-1:0] disp_line,
    input wire logic [UW-1:0] disp_unit,
    output logic [47:0] disp_data,
    output logic bank_sel
);

    localparam int AW = 1 + LW + UW;

    if (NUM_LINES < 2 || NUM_LINES > 64 || (NUM_LINES & (NUM_LINES - 1)) != 0 ||
        NUM_UNITS < 2 || (NUM_UNITS & (NUM_UNITS - 1)) != 0) begin : g_bad_geometry
        $error("unsupported bank geometry");
    end

    // head word decode
    function automatic cascade_gs_pkg::cmd_kind_t decode_head(input logic [15:0] h);
        if (h == cascade_gs_pkg::CMD_GS_WRITE)
            return cascade_gs_pkg::K_GS_WRITE;
        if (h == cascade_gs_pkg::CMD_VSYNC)
            return cascade_gs_pkg::K_VSYNC;
        if (h == cascade_gs_pkg::CMD_GS_READ)
            return cascade_gs_pkg::K_READ;
        return cascade_gs_pkg::K_NONE;
    endfunction

    // own 48 bits, blue word first, red word last
    function automatic cascade_gs_pkg::gs_unit_t own_unit(
        input logic [cascade_gs_pkg::DLY_LEN-1:0] d);
        logic [47:0] u;
        u = '0;
        for (int w = 0; w < cascade_gs_pkg::WORDS_PER_UNIT; w++)
            u[47 - cascade_gs_pkg::DATA_BITS * w -: cascade_gs_pkg::DATA_BITS] =
                d[cascade_gs_pkg::DLY_LEN - 2 - cascade_gs_pkg::WORD_BITS * w -:
                  cascade_gs_pkg::DATA_BITS];
        return u;
    endfunction

    // three serial words with check bits from one unit
    function automatic logic [cascade_gs_pkg::OWN_BITS-1:0] build_words(input logic [47:0] u);
        logic [cascade_gs_pkg::OWN_BITS-1:0] v;
        v = '0;
        for (int w = 0; w < cascade_gs_pkg::WORDS_PER_UNIT; w++)
            v[cascade_gs_pkg::OWN_BITS - 1 - cascade_gs_pkg::WORD_BITS * w -:
              cascade_gs_pkg::WORD_BITS] =
                {u[47 - cascade_gs_pkg::DATA_BITS * w -: cascade_gs_pkg::DATA_BITS],
                 ~u[48 - cascade_gs_pkg::DATA_BITS * (w + 1)]};
        return v;
    endfunction

    // ---------------- link domain ----------------
    logic [2:0] lsync_q;
    logic sin_s;
    logic ack_s;
    logic link_en;
    cascade_gs_pkg::link_state_t state_reg;
    cascade_gs_pkg::cmd_kind_t kind_reg;
    logic [4:0] ones_reg;
    logic [4:0] bit_cnt_reg;
    logic [15:0] word_sh_reg;
    logic [cascade_gs_pkg::DLY_LEN-1:0] dly_reg;
    logic [6:0] post_cnt_reg;
    logic [cascade_gs_pkg::OWN_BITS-1:0] inj_sh_reg;
    logic ack_prev_reg;
    logic ev_tgl_reg;
    logic rd_req_tgl_reg;
    cascade_gs_pkg::link_event_t ev_reg;
    logic end_det;
    logic head_done;
    logic in_inject;
    logic in_trail;
    logic ack_tgl_reg;
    logic [47:0] rd_hold_reg;

    sig_sync #(
        .WIDTH(3),
        .RST_VAL({cascade_gs_pkg::LINE_IDLE_LEVEL, 2'h0})
    ) u_link_sync (
        .clk(chain_clk),
        .rst(sys_rst),
        .d({chain_serial_in, ack_tgl_reg, clk_en}),
        .q(lsync_q)
    );

    assign sin_s = lsync_q[2];
    assign ack_s = lsync_q[1];
    assign link_en = lsync_q[0];

    // end marker, head completion and insertion windows
    assign end_det = sin_s && ones_reg == 5'(cascade_gs_pkg::END_ONES - 1) &&
                     (state_reg == cascade_gs_pkg::L_HEAD || state_reg == cascade_gs_pkg::L_BODY);
    assign head_done = state_reg == cascade_gs_pkg::L_HEAD &&
                       bit_cnt_reg == 5'(cascade_gs_pkg::WORD_BITS - 1);
    assign in_inject = state_reg == cascade_gs_pkg::L_INJECT &&
                       post_cnt_reg >= 7'(cascade_gs_pkg::INJ_START) &&
                       post_cnt_reg <= 7'(cascade_gs_pkg::INJ_END);
    assign in_trail = state_reg == cascade_gs_pkg::L_INJECT &&
                      post_cnt_reg > 7'(cascade_gs_pkg::INJ_END);

    // run of highs, restarted on each body word boundary
    // a last check bit of one must not join the end marker and shift the own bits
    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ones_reg <= 5'h00;
        else if (link_en)
        begin
            if (!sin_s)
                ones_reg <= 5'h00;
            else if (state_reg == cascade_gs_pkg::L_BODY && bit_cnt_reg == 5'h00)
                ones_reg <= 5'h01;
            else if (ones_reg != 5'(cascade_gs_pkg::END_ONES))
                ones_reg <= ones_reg + 5'h01;
        end
    end

    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= cascade_gs_pkg::L_IDLE;
            kind_reg <= cascade_gs_pkg::K_NONE;
            bit_cnt_reg <= 5'h00;
            word_sh_reg <= 16'h0000;
        end
        else if (link_en)
        begin
            unique case (state_reg)
                cascade_gs_pkg::L_IDLE:
                begin
                    bit_cnt_reg <= 5'h00;
                    if (!sin_s)
                        state_reg <= cascade_gs_pkg::L_HEAD;
                end
                cascade_gs_pkg::L_HEAD:
                begin
                    word_sh_reg <= {word_sh_reg[14:0], sin_s};
                    bit_cnt_reg <= head_done ? 5'h00 : bit_cnt_reg + 5'h01;
                    if (head_done)
                    begin
                        kind_reg <= decode_head(word_sh_reg);
                        state_reg <= cascade_gs_pkg::L_BODY;
                    end
                end
                cascade_gs_pkg::L_BODY:
                begin
                    if (bit_cnt_reg == 5'(cascade_gs_pkg::WORD_BITS - 1))
                        bit_cnt_reg <= 5'h00;
                    else
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (end_det)
                        state_reg <= (kind_reg == cascade_gs_pkg::K_READ) ?
                                     cascade_gs_pkg::L_INJECT : cascade_gs_pkg::L_IDLE;
                end
                cascade_gs_pkg::L_INJECT:
                begin
                    if (post_cnt_reg == 7'(cascade_gs_pkg::INJ_DONE))
                        state_reg <= cascade_gs_pkg::L_IDLE;
                end
                default:
                    state_reg <= cascade_gs_pkg::L_IDLE;
            endcase
        end
    end

    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
            dly_reg <= '1;
        else if (link_en)
        begin
            if (end_det && kind_reg == cascade_gs_pkg::K_GS_WRITE)
                dly_reg <= {{cascade_gs_pkg::OWN_BITS{1'b1}},
                            dly_reg[cascade_gs_pkg::END_ONES-2:0], sin_s};
            else
                dly_reg <= {dly_reg[cascade_gs_pkg::DLY_LEN-2:0], sin_s};
        end
    end

    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ev_reg <= '0;
            ev_tgl_reg <= 1'b0;
        end
        else if (link_en && end_det &&
                 (kind_reg == cascade_gs_pkg::K_GS_WRITE || kind_reg == cascade_gs_pkg::K_VSYNC))
        begin
            ev_reg.kind <= kind_reg;
            ev_reg.unit <= own_unit(dly_reg);
            ev_tgl_reg <= ~ev_tgl_reg;
        end
    end

    // read request toggled as the head is decoded
    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_req_tgl_reg <= 1'b0;
        else if (link_en && head_done && decode_head(word_sh_reg) == cascade_gs_pkg::K_READ)
            rd_req_tgl_reg <= ~rd_req_tgl_reg;
    end

    // insertion bit counter after the end marker
    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
            post_cnt_reg <= 7'h00;
        else if (link_en)
        begin
            if (end_det && kind_reg == cascade_gs_pkg::K_READ)
                post_cnt_reg <= 7'h01;
            else if (state_reg == cascade_gs_pkg::L_INJECT)
                post_cnt_reg <= post_cnt_reg + 7'h01;
            else
                post_cnt_reg <= 7'h00;
        end
    end

    // readback words, loaded on answer from core
    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ack_prev_reg <= 1'b0;
            inj_sh_reg <= '1;
        end
        else if (link_en)
        begin
            ack_prev_reg <= ack_s;
            if (ack_s != ack_prev_reg)
                inj_sh_reg <= build_words(rd_hold_reg);
            else if (in_inject)
                inj_sh_reg <= {inj_sh_reg[cascade_gs_pkg::OWN_BITS-2:0], 1'b1};
        end
    end

    // forwarded stream with insertion and fresh end marker
    always_ff @(posedge chain_clk or posedge sys_rst)
    begin
        if (sys_rst)
            chain_serial_out <= cascade_gs_pkg::LINE_IDLE_LEVEL;
        else if (link_en)
        begin
            if (in_inject)
                chain_serial_out <= inj_sh_reg[cascade_gs_pkg::OWN_BITS-1];
            else if (in_trail)
                chain_serial_out <= cascade_gs_pkg::LINE_IDLE_LEVEL;
            else
                chain_serial_out <= dly_reg[cascade_gs_pkg::DLY_LEN-1];
        end
    end

    // ---------------- core domain ----------------
    logic [1:0] csync_q;
    logic ev_seen_reg;
    logic rd_seen_reg;
    logic ev_fire;
    logic rd_fire;
    logic gs_wr;
    logic vsync_fire;
    logic bank_sel_reg;
    logic [UW-1:0] unit_reg;
    logic [LW-1:0] line_reg;
    logic [47:0] disp_data_reg;
    logic [5:0] scan_last;
    logic [AW-1:0] wr_addr;
    cascade_gs_pkg::gs_unit_t gs_mem [0:(1 << AW) - 1];

    sig_sync #(
        .WIDTH(2),
        .RST_VAL(2'h0)
    ) u_core_sync (
        .clk(clock),
        .rst(sys_rst),
        .d({ev_tgl_reg, rd_req_tgl_reg}),
        .q(csync_q)
    );

    // events seen from the link
    assign ev_fire = clk_en && (csync_q[1] != ev_seen_reg);
    assign rd_fire = clk_en && (csync_q[0] != rd_seen_reg);
    assign gs_wr = ev_fire && ev_reg.kind == cascade_gs_pkg::K_GS_WRITE;
    assign vsync_fire = ev_fire && ev_reg.kind == cascade_gs_pkg::K_VSYNC;
    assign scan_last = config_word_zero[cascade_gs_pkg::SCAN_MSB:cascade_gs_pkg::SCAN_LSB];
    // writes go to the bank named by the flag
    assign wr_addr = {bank_sel_reg, line_reg, unit_reg};
    assign bank_sel = bank_sel_reg;
    assign disp_data = disp_data_reg;

    // toggle trackers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ev_seen_reg <= 1'b0;
            rd_seen_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ev_seen_reg <= csync_q[1];
            rd_seen_reg <= csync_q[0];
        end
    end

    // single flag, reset zero, toggles on frame sync
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            bank_sel_reg <= cascade_gs_pkg::BANK_SEL_RESET;
        else if (vsync_fire)
            bank_sel_reg <= ~bank_sel_reg;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            unit_reg <= '0;
            line_reg <= '0;
        end
        else if (vsync_fire)
        begin
            unit_reg <= '0;
            line_reg <= '0;
        end
        else if (gs_wr)
        begin
            unit_reg <= unit_reg + UW'(1);
            if (unit_reg == UW'(NUM_UNITS - 1))
            begin
                if (6'(line_reg) >= scan_last || line_reg == LW'(NUM_LINES - 1))
                    line_reg <= '0;
                else
                    line_reg <= line_reg + LW'(1);
            end
        end
    end

    // latch unit into the write bank
    always_ff @(posedge clock)
    begin
        if (gs_wr)
            gs_mem[wr_addr] <= ev_reg.unit;
    end

    // display read from the other bank
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            disp_data_reg <= 48'h000000000000;
        else if (clk_en)
            disp_data_reg <= gs_mem[{~bank_sel_reg, disp_line, disp_unit}];
    end

    // readback snapshot and answer toggle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_hold_reg <= 48'h000000000000;
            ack_tgl_reg <= 1'b0;
        end
        else if (rd_fire)
        begin
            rd_hold_reg <= readback_data;
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

    // ---------------- checks ----------------
    AST_BANK_TOGGLE: assert property (@(posedge clock) disable iff (sys_rst)
        vsync_fire |=> bank_sel_reg != $past(bank_sel_reg))
        else $error("bank flag did not toggle on frame sync");

    AST_BANK_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        !vsync_fire |=> $stable(bank_sel_reg))
        else $error("bank flag changed without frame sync");

    AST_UNIT_ADV: assert property (@(posedge clock) disable iff (sys_rst)
        (gs_wr && !vsync_fire) |=> unit_reg == $past(unit_reg) + UW'(1))
        else $error("unit counter did not advance");

    AST_LINE_STEP: assert property (@(posedge clock) disable iff (sys_rst)
        (gs_wr && unit_reg != UW'(NUM_UNITS - 1)) |=> $stable(line_reg))
        else $error("line counter moved inside a line");

    AST_WRITE_BANK: assert property (@(posedge clock) disable iff (sys_rst)
        gs_wr |=> gs_mem[{$past(bank_sel_reg), $past(line_reg), $past(unit_reg)}] ==
                  $past(ev_reg.unit))
        else $error("write aimed at displayed bank");

    AST_END_IDLE: assert property (@(posedge chain_clk) disable iff (sys_rst)
        (link_en && end_det && kind_reg != cascade_gs_pkg::K_READ)
        |=> state_reg == cascade_gs_pkg::L_IDLE)
        else $error("end marker did not return to idle");

    AST_STRIP: assert property (@(posedge chain_clk) disable iff (sys_rst)
        (link_en && end_det && kind_reg == cascade_gs_pkg::K_GS_WRITE)
        |=> &dly_reg[cascade_gs_pkg::DLY_LEN-1:cascade_gs_pkg::END_ONES])
        else $error("own write bits were forwarded");

    AST_INJECT_BIT: assert property (@(posedge chain_clk) disable iff (sys_rst)
        (link_en && in_inject) |=> chain_serial_out == $past(inj_sh_reg[50]))
        else $error("inserted bit not driven out");

    AST_CHECK_BIT: assert property (@(posedge chain_clk) disable iff (sys_rst)
        (link_en && state_reg == cascade_gs_pkg::L_INJECT && post_cnt_reg == 7'h44)
        |=> chain_serial_out == !$past(chain_serial_out))
        else $error("inserted check bit not inverted");

endmodule // cascade_gs_memory_banks
`default_nettype wire

// ---- chain_ctrl_model.sv ----
// controller model at the far end of the chain: link clock, frames, output watch
// assumes the block samples its serial input on the rising link clock edge
`timescale 1ns/1ps
`default_nettype none
module chain_ctrl_model (
    // link pins
    output logic chain_clk,
    output logic chain_serial_in,
    input wire logic chain_serial_out
);
    logic [68:0] out_hist;
    int zero_cnt;

    // continuous link clock, line idles high
    initial
    begin
        chain_clk = 1'b0;
        chain_serial_in = 1'b1;
        zero_cnt = 0;
        #3;
        forever #40 chain_clk = ~chain_clk;
    end

    // history and zero count of what leaves the chain
    always @(posedge chain_clk)
    begin
        out_hist <= {out_hist[67:0], chain_serial_out};
        zero_cnt <= zero_cnt + (chain_serial_out ? 0 : 1);
    end

    task automatic put_bit(input logic b);
        @(posedge chain_clk);
        #1 chain_serial_in = b;
    endtask

    // msb first, inverted lsb as check
    task automatic put_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
            put_bit(w[i]);
        put_bit(~w[0]);
    endtask

    task automatic send_frame(input logic [15:0] head, input logic [47:0] unit, input bit has_unit);
        put_bit(1'b0);
        put_word(head);
        if (has_unit)
        begin
            put_word(unit[47:32]);
            put_word(unit[31:16]);
            put_word(unit[15:0]);
        end
        for (int i = 0; i < 18; i++)
            put_bit(1'b1);
    endtask

    // wait up to 300 link clocks for the read data pattern at the chain output
    task automatic find_read(input logic [47:0] v, output bit ok);
        logic [68:0] pat;
        pat = {v[47:32], ~v[32], v[31:16], ~v[16], v[15:0], ~v[0], 18'h3ffff};
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++)
        begin
            @(posedge chain_clk);
            #2 ok = (out_hist === pat);
        end
    endtask
endmodule // chain_ctrl_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the chain data path and grayscale banks
// assumes the controller model drives the link and clk_en stays high except during t_freeze
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, sys_rst, clk_en, chain_clk, chain_serial_in, chain_serial_out, bank_sel;
    logic [47:0] config_word_zero, readback_data, disp_data, v;
    logic [5:0] disp_line;
    logic [3:0] disp_unit;
    int err_total, checks_done;
    bit ok;

    cascade_gs_memory_banks u_cascade_gs_memory_banks (.clock(clock), .sys_rst(sys_rst),
        .clk_en(clk_en), .chain_clk(chain_clk), .chain_serial_in(chain_serial_in),
        .chain_serial_out(chain_serial_out), .config_word_zero(config_word_zero),
        .readback_data(readback_data), .disp_line(disp_line), .disp_unit(disp_unit),
        .disp_data(disp_data), .bank_sel(bank_sel));
    chain_ctrl_model u_chain_ctrl_model (.chain_clk(chain_clk),
        .chain_serial_in(chain_serial_in), .chain_serial_out(chain_serial_out));

    // core clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic final_report;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [47:0] unit_val(input int i);
        return {16'hb000 + i[15:0], 16'h6000 + i[15:0], 16'h2000 + i[15:0]};
    endfunction

    // read one display unit, one clock latency
    task automatic peek(input int line, input int unit);
        @(posedge clock);
        #1 disp_line = line[5:0];
        disp_unit = unit[3:0];
        @(posedge clock);
        #1 v = disp_data;
    endtask

    // bounded wait for the bank flag to reach a value
    task automatic wait_bank(input logic exp);
        int n;
        n = 0;
        while (bank_sel !== exp && n < 400)
        begin
            @(posedge clock);
            #1 n++;
        end
        check("bank_sel", {47'h0, exp}, {47'h0, bank_sel});
        if (n >= 400)
            final_report();
    endtask

    task automatic t_reset;
        #2;
        check("bank_sel after reset", 48'h0, {47'h0, bank_sel});
        check("idle output", 48'h1, {47'h0, chain_serial_out});
    endtask

    // own unit stripped, only start and head pass on, then swap shows it
    task automatic t_strip;
        int exp_z;
        exp_z = 1 + 16 - $countones(cascade_gs_pkg::CMD_GS_WRITE) + (cascade_gs_pkg::CMD_GS_WRITE[0] ? 1 : 0);
        u_chain_ctrl_model.zero_cnt = 0;
        u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_GS_WRITE, unit_val(99), 1'b1);
        repeat (90) @(posedge chain_clk);
        check("forwarded zeros", 48'(exp_z), 48'(u_chain_ctrl_model.zero_cnt));
        u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_VSYNC, 48'h0, 1'b0);
        wait_bank(1'b1);
        peek(0, 0);
        check("bank A unit", unit_val(99), v);
        check("red field", 48'h2063, {32'h0, v[15:0]});
    endtask

    // 33 writes over two active lines, display bank untouched meanwhile
    task automatic t_fill;
        for (int i = 0; i < 33; i++)
            u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_GS_WRITE, unit_val(i), 1'b1);
        peek(0, 0);
        check("display bank kept", unit_val(99), v);
        u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_VSYNC, 48'h0, 1'b0);
        wait_bank(1'b0);
        peek(0, 1);
        check("line0 unit1", unit_val(1), v);
        peek(1, 0);
        check("line1 unit0", unit_val(16), v);
        peek(1, 15);
        check("line1 unit15", unit_val(31), v);
        peek(0, 0);
        check("line wrap", unit_val(32), v);
    endtask

    // enable low freezes both domains, so a frame sync sent then is lost
    task automatic t_freeze;
        clk_en = 1'b0;
        u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_VSYNC, 48'h0, 1'b0);
        repeat (8) @(posedge chain_clk);
        #2 check("frozen bank_sel", 48'h0, {47'h0, bank_sel});
        @(posedge clock);
        #1 clk_en = 1'b1;
        repeat (4) @(posedge chain_clk);
        u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_VSYNC, 48'h0, 1'b0);
        wait_bank(1'b1);
    endtask

    task automatic t_read;
        u_chain_ctrl_model.send_frame(cascade_gs_pkg::CMD_GS_READ, 48'h0, 1'b0);
        u_chain_ctrl_model.find_read(readback_data, ok);
        check("read insertion", 48'h1, {47'h0, ok});
    endtask

    // main sequence
    initial
    begin
        err_total = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        config_word_zero = 48'h0000_0001_0000;
        readback_data = 48'hc3a5_5a3c_0f0e;
        disp_line = 6'h0;
        disp_unit = 4'h0;
        repeat (2) @(posedge chain_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge chain_clk);
        t_reset();
        t_strip();
        t_fill();
        t_freeze();
        t_read();
        final_report();
    end
endmodule // testbench
`default_nettype wire
